// ===== otp_query_params.svh
// constants for the security register, lock word and query table link
`ifndef OTP_QUERY_PARAMS_SVH
`define OTP_QUERY_PARAMS_SVH

// ----------------------------------------------------------------
// link command codes (low data byte)
// ----------------------------------------------------------------
`define CMD_READ_ARRAY    8'hFF
`define CMD_READ_STATUS   8'h70
`define CMD_CLEAR_STATUS  8'h50
`define CMD_READ_IDENT    8'h90
`define CMD_QUERY_READ    8'h98
`define CMD_SEC_PROG      8'hC0

// ----------------------------------------------------------------
// security region map
// ----------------------------------------------------------------
`define SEC_BASE          16'h0080
`define SEC_LAST          16'h0109
`define LOCK0_ADDR        16'h0080
`define LOCK1_ADDR        16'h0089
`define SEC_WORDS         8'h8A
`define LOCK0_IDX         8'h00
`define LOCK1_IDX         8'h09
`define FACTORY_FIRST     8'h01
`define FACTORY_LAST      8'h04
`define USER0_LAST        8'h08
`define REG1_FIRST        8'h0A
`define LOCK0_FACTORY_BIT 0
`define LOCK0_USER_BIT    1
`define LOCK0_RESET       16'hFFFE
`define ERASED_WORD       16'hFFFF

// ----------------------------------------------------------------
// status word
// ----------------------------------------------------------------
`define SR_READY          7
`define SR_PROG_ERR       4
`define SR_LOCK_ERR       1
`define SR_RESET          8'h80

// ----------------------------------------------------------------
// query table
// ----------------------------------------------------------------
`define Q_OFS_Q           16'h0010
`define Q_OFS_R           16'h0011
`define Q_OFS_Y           16'h0012
`define Q_OFS_CMDSET_LO   16'h0013
`define Q_OFS_CMDSET_HI   16'h0014
`define Q_OFS_PTR_LO      16'h0015
`define Q_OFS_PTR_HI      16'h0016
`define Q_OFS_ALT_LO      16'h0017
`define Q_OFS_ALT_HI      16'h0018
`define Q_OFS_SEC_LO      16'h0019
`define Q_OFS_SEC_HI      16'h001A
`define Q_SYSIF_BASE      16'h001B
`define Q_GEOM_BASE       16'h0027
`define Q_CODE_Q          8'h51
`define Q_CODE_R          8'h52
`define Q_CODE_Y          8'h59
`define Q_CODE_PTR_LO     8'h0A
`define Q_CODE_PTR_HI     8'h01
`define Q_CODE_NONE       8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS     40
`define PROG_TIME_NS      200
`define PROG_CYCLES       ((`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------
// host register port
// ----------------------------------------------------------------
`define HREG_CTRL         4'h0
`define HREG_ADDR         4'h1
`define HREG_DATA         4'h2
`define HREG_RESULT       4'h3
`define OP_PROG           3'h1
`define OP_READ_ID        3'h2
`define OP_QUERY          3'h3
`define OP_STATUS         3'h4
`define OP_CLEAR          3'h5

`endif

// ===== otp_query_pkg.sv
// types shared by both ends of the security register link
package otp_query_pkg;
	typedef enum logic [1:0] {M_ARRAY, M_STATUS, M_IDENT, M_QUERY} read_mode_t;
	typedef enum logic [1:0] {P_IDLE, P_DATA, P_BUSY} prog_state_t;
	typedef enum logic [1:0] {H_IDLE, H_CMD, H_SECOND, H_WAIT} host_state_t;
endpackage

// ===== flash_link_if.sv
// synchronous command link between host controller and flash device
`timescale 1ns/1ps
interface flash_link_if;
	logic        wr;
	logic        rd;
	logic [15:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic        rvalid;

	modport device (input wr, input rd, input addr, input wdata, output rdata, output rvalid);
	modport host (output wr, output rd, output addr, output wdata, input rdata, input rvalid);
endinterface // flash_link_if

// ===== otp_store.sv
// security register words and lock words held in flip-flops
`timescale 1ns/1ps
`include "otp_query_params.svh"
module otp_store #(
	// factory segment content, value arbitrary
	parameter logic [63:0] FACTORY_ID = 64'h0123_4567_89AB_CDEF
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        prog_en,
	input  wire logic [7:0]  prog_idx,
	input  wire logic [15:0] prog_data,
	input  wire logic [7:0]  rd_idx,
	output logic [15:0]      rd_data,
	output logic             prog_locked
);
	logic [15:0] words      [0:`SEC_WORDS-1];
	logic [15:0] next_words [0:`SEC_WORDS-1];
	logic [7:0]  rel;

	function automatic logic [15:0] init_word(input int i);
		if (i == `LOCK0_IDX)
			return `LOCK0_RESET;
		if (i >= `FACTORY_FIRST && i <= `FACTORY_LAST)
			return FACTORY_ID[(i - 1) * 16 +: 16];
		return `ERASED_WORD;
	endfunction

	// ----------------------------------------------------------------
	// lock lookup for the word being programmed
	// ----------------------------------------------------------------
	always_comb begin
		rel = prog_idx - `REG1_FIRST;
		prog_locked = 1'b0;
		if (prog_idx >= `FACTORY_FIRST && prog_idx <= `FACTORY_LAST)
			prog_locked = !words[`LOCK0_IDX][`LOCK0_FACTORY_BIT];
		else if (prog_idx > `FACTORY_LAST && prog_idx <= `USER0_LAST)
			prog_locked = !words[`LOCK0_IDX][`LOCK0_USER_BIT];
		// lock word one bit per register
		else if (prog_idx >= `REG1_FIRST && prog_idx < `SEC_WORDS)
			prog_locked = !words[`LOCK1_IDX][rel[6:3]];
	end

	assign rd_data = (rd_idx < `SEC_WORDS) ? words[rd_idx] : 16'h0000;

	// ----------------------------------------------------------------
	// programming only clears bits
	// ----------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < `SEC_WORDS; i++)
			next_words[i] = words[i];
		if (prog_en && prog_idx < `SEC_WORDS)
			next_words[prog_idx] = words[prog_idx] & prog_data;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < `SEC_WORDS; i++)
				words[i] <= init_word(i);
		end else begin
			words <= next_words;
		end
	end
endmodule // otp_store

// ===== flash_device_end.sv
// device end: security register programming, lock words and query table
`timescale 1ns/1ps
`include "otp_query_params.svh"
// Function
// - host sends program command, then data
// - one 16-bit word per program operation
// - program outside region sets program error
// - locked target: no change, both errors
// - host locks by program then lock data
// - lock words sit at 0x80 and 0x89
// - factory segment lock bit preprogrammed
// - host locks user segment with 0xFFFD
// - lock word one bit n locks register
// - cleared lock bits can never be set again; here RST reloads the lock words to their reset values
// - query table only after query command
// - query byte on low lane, high zero
// - query offsets are word addresses from 0x10
// - offsets 0x10 to 0x12 return Q R Y
// - 13h-14h return command set code
// - 15h-16h return table pointer 0A 01
// - 17h-18h return zero, no alternate set
// - 0x19 and 0x1A return zero
// - system interface 1Bh, geometry 27h sections return zero
// - identifier read returns security words
module flash_device_end #(
	// command set code, value arbitrary
	parameter logic [15:0] PRIMARY_CMDSET = 16'h00A5
) (
	input  wire logic    CLK,
	input  wire logic    RST,
	flash_link_if.device LINK,
	output logic [7:0]   STATUS
);
	otp_query_pkg::read_mode_t  mode;
	otp_query_pkg::read_mode_t  next_mode;
	otp_query_pkg::prog_state_t pstate;
	otp_query_pkg::prog_state_t next_pstate;
	logic [15:0]                prog_addr;
	logic [15:0]                next_prog_addr;
	logic [7:0]                 busy_cnt;
	logic [7:0]                 next_busy_cnt;
	logic                       prog_err;
	logic                       next_prog_err;
	logic                       lock_err;
	logic                       next_lock_err;
	logic [15:0]                rdata;
	logic [15:0]                next_rdata;
	logic                       rvalid;
	logic                       next_rvalid;
	logic [7:0]                 next_status;
	logic                       store_wr;
	logic [15:0]                store_rd;
	logic                       store_locked;

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	function automatic logic sec_hit(input logic [15:0] a);
		return (a >= `SEC_BASE) && (a <= `SEC_LAST);
	endfunction

	// region index from lock word zero address
	function automatic logic [7:0] sec_idx(input logic [15:0] a);
		logic [15:0] d;
		d = a - `SEC_BASE;
		return d[7:0];
	endfunction

	function automatic logic [7:0] status_of(input logic busy, input logic pe,
		input logic le);
		logic [7:0] s;
		s = 8'h00;
		s[`SR_READY] = !busy;
		s[`SR_PROG_ERR] = pe;
		s[`SR_LOCK_ERR] = le;
		return s;
	endfunction

	function automatic logic [7:0] query_byte(input logic [15:0] a);
		logic [7:0] b;
		b = `Q_CODE_NONE;
		case (a)
			`Q_OFS_Q: b = `Q_CODE_Q;
			`Q_OFS_R: b = `Q_CODE_R;
			`Q_OFS_Y: b = `Q_CODE_Y;
			`Q_OFS_CMDSET_LO: b = PRIMARY_CMDSET[7:0];
			`Q_OFS_CMDSET_HI: b = PRIMARY_CMDSET[15:8];
			`Q_OFS_PTR_LO: b = `Q_CODE_PTR_LO;
			`Q_OFS_PTR_HI: b = `Q_CODE_PTR_HI;
			`Q_OFS_ALT_LO: b = `Q_CODE_NONE;
			`Q_OFS_ALT_HI: b = `Q_CODE_NONE;
			`Q_OFS_SEC_LO: b = `Q_CODE_NONE;
			`Q_OFS_SEC_HI: b = `Q_CODE_NONE;
			default: b = `Q_CODE_NONE;
		endcase
		// sections from Q_SYSIF_BASE and Q_GEOM_BASE not held
		if (a >= `Q_SYSIF_BASE)
			b = `Q_CODE_NONE;
		return b;
	endfunction

	// ----------------------------------------------------------------
	// security word storage
	// ----------------------------------------------------------------
	otp_store u_store (
		.clk         (CLK),
		.rst         (RST),
		.prog_en     (store_wr),
		.prog_idx    (sec_idx(prog_addr)),
		.prog_data   (LINK.wdata),
		.rd_idx      (sec_idx(LINK.addr)),
		.rd_data     (store_rd),
		.prog_locked (store_locked)
	);

	// ----------------------------------------------------------------
	// command decode and program sequencing
	// ----------------------------------------------------------------
	always_comb begin
		next_mode = mode;
		next_pstate = pstate;
		next_prog_addr = prog_addr;
		next_busy_cnt = busy_cnt;
		next_prog_err = prog_err;
		next_lock_err = lock_err;
		store_wr = 1'b0;
		case (pstate)
			otp_query_pkg::P_IDLE: begin
				if (LINK.wr) begin
					case (LINK.wdata[7:0])
						`CMD_READ_ARRAY: next_mode = otp_query_pkg::M_ARRAY;
						`CMD_READ_STATUS: next_mode = otp_query_pkg::M_STATUS;
						`CMD_READ_IDENT: next_mode = otp_query_pkg::M_IDENT;
						`CMD_QUERY_READ: next_mode = otp_query_pkg::M_QUERY;
						`CMD_CLEAR_STATUS: begin
							next_prog_err = 1'b0;
							next_lock_err = 1'b0;
						end
						`CMD_SEC_PROG: begin
							next_pstate = otp_query_pkg::P_DATA;
							next_prog_addr = LINK.addr;
							next_mode = otp_query_pkg::M_STATUS;
						end
						default: next_mode = mode;
					endcase
				end
			end
			otp_query_pkg::P_DATA: begin
				if (LINK.wr) begin
					next_pstate = otp_query_pkg::P_BUSY;
					next_busy_cnt = 8'(`PROG_CYCLES);
					if (!sec_hit(prog_addr)) begin
						next_prog_err = 1'b1;
					end else if (store_locked) begin
						next_prog_err = 1'b1;
						next_lock_err = 1'b1;
					end else begin
						store_wr = 1'b1;
					end
				end
			end
			otp_query_pkg::P_BUSY: begin
				next_busy_cnt = busy_cnt - 8'h01;
				if (busy_cnt == 8'h01)
					next_pstate = otp_query_pkg::P_IDLE;
			end
			default: next_pstate = otp_query_pkg::P_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// read data path
	// ----------------------------------------------------------------
	always_comb begin
		next_rvalid = LINK.rd;
		next_rdata = 16'h0000;
		next_status = status_of(next_pstate == otp_query_pkg::P_BUSY,
			next_prog_err, next_lock_err);
		if (LINK.rd) begin
			if (pstate != otp_query_pkg::P_IDLE || mode == otp_query_pkg::M_STATUS) begin
				next_rdata = {8'h00, STATUS};
			end else begin
				case (mode)
					otp_query_pkg::M_IDENT:
						next_rdata = sec_hit(LINK.addr) ? store_rd : 16'h0000;
					otp_query_pkg::M_QUERY:
						next_rdata = {8'h00, query_byte(LINK.addr)};
					default: next_rdata = `ERASED_WORD;
				endcase
			end
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			mode <= otp_query_pkg::M_ARRAY;
			pstate <= otp_query_pkg::P_IDLE;
			prog_addr <= 16'h0000;
			busy_cnt <= 8'h00;
			prog_err <= 1'b0;
			lock_err <= 1'b0;
			rdata <= 16'h0000;
			rvalid <= 1'b0;
			STATUS <= `SR_RESET;
		end else begin
			mode <= next_mode;
			pstate <= next_pstate;
			prog_addr <= next_prog_addr;
			busy_cnt <= next_busy_cnt;
			prog_err <= next_prog_err;
			lock_err <= next_lock_err;
			rdata <= next_rdata;
			rvalid <= next_rvalid;
			STATUS <= next_status;
		end
	end

	assign LINK.rdata = rdata;
	assign LINK.rvalid = rvalid;
endmodule // flash_device_end

// ===== flash_host_end.sv
// host end: register port that turns orders into link command sequences
`timescale 1ns/1ps
`include "otp_query_params.svh"
module flash_host_end (
	input  wire logic        CLK,
	input  wire logic        RST,
	flash_link_if.host       LINK,
	input  wire logic [3:0]  ADDR,
	input  wire logic [15:0] WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic [15:0]      RDATA
);
	otp_query_pkg::host_state_t hstate;
	otp_query_pkg::host_state_t next_hstate;
	logic [2:0]                 op;
	logic [2:0]                 next_op;
	logic [15:0]                tgt_addr;
	logic [15:0]                next_tgt_addr;
	logic [15:0]                tgt_data;
	logic [15:0]                next_tgt_data;
	logic [15:0]                result;
	logic [15:0]                next_result;
	logic [15:0]                next_rdata;
	logic                       next_lwr;
	logic                       next_lrd;
	logic [15:0]                next_laddr;
	logic [15:0]                next_lwdata;

	function automatic logic [7:0] cmd_of(input logic [2:0] o);
		case (o)
			`OP_PROG: return `CMD_SEC_PROG;
			`OP_READ_ID: return `CMD_READ_IDENT;
			`OP_QUERY: return `CMD_QUERY_READ;
			`OP_STATUS: return `CMD_READ_STATUS;
			`OP_CLEAR: return `CMD_CLEAR_STATUS;
			default: return `CMD_READ_ARRAY;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// register port and sequencer
	// ----------------------------------------------------------------
	always_comb begin
		next_hstate = hstate;
		next_op = op;
		next_tgt_addr = tgt_addr;
		next_tgt_data = tgt_data;
		next_result = result;
		next_rdata = 16'h0000;
		next_lwr = 1'b0;
		next_lrd = 1'b0;
		next_laddr = LINK.addr;
		next_lwdata = LINK.wdata;
		if (RD) begin
			case (ADDR)
				`HREG_CTRL: next_rdata = {15'h0000, hstate != otp_query_pkg::H_IDLE};
				`HREG_ADDR: next_rdata = tgt_addr;
				`HREG_DATA: next_rdata = tgt_data;
				`HREG_RESULT: next_rdata = result;
				default: next_rdata = 16'h0000;
			endcase
		end
		if (WR && ADDR == `HREG_ADDR)
			next_tgt_addr = WDATA;
		if (WR && ADDR == `HREG_DATA)
			next_tgt_data = WDATA;
		case (hstate)
			otp_query_pkg::H_IDLE: begin
				if (WR && ADDR == `HREG_CTRL && WDATA[2:0] >= `OP_PROG
					&& WDATA[2:0] <= `OP_CLEAR) begin
					next_op = WDATA[2:0];
					next_hstate = otp_query_pkg::H_CMD;
				end
			end
			otp_query_pkg::H_CMD: begin
				next_lwr = 1'b1;
				next_laddr = (op == `OP_STATUS || op == `OP_CLEAR) ? 16'h0000 : tgt_addr;
				next_lwdata = {8'h00, cmd_of(op)};
				next_hstate = (op == `OP_CLEAR) ? otp_query_pkg::H_IDLE
					: otp_query_pkg::H_SECOND;
			end
			otp_query_pkg::H_SECOND: begin
				next_laddr = (op == `OP_STATUS) ? 16'h0000 : tgt_addr;
				if (op == `OP_PROG) begin
					next_lwr = 1'b1;
					next_lwdata = tgt_data;
					next_hstate = otp_query_pkg::H_IDLE;
				end else begin
					next_lrd = 1'b1;
					next_hstate = otp_query_pkg::H_WAIT;
				end
			end
			otp_query_pkg::H_WAIT: begin
				if (LINK.rvalid) begin
					next_result = LINK.rdata;
					next_hstate = otp_query_pkg::H_IDLE;
				end
			end
			default: next_hstate = otp_query_pkg::H_IDLE;
		endcase
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			hstate <= otp_query_pkg::H_IDLE;
			op <= 3'h0;
			tgt_addr <= 16'h0000;
			tgt_data <= 16'h0000;
			result <= 16'h0000;
			RDATA <= 16'h0000;
			LINK.wr <= 1'b0;
			LINK.rd <= 1'b0;
			LINK.addr <= 16'h0000;
			LINK.wdata <= 16'h0000;
		end else begin
			hstate <= next_hstate;
			op <= next_op;
			tgt_addr <= next_tgt_addr;
			tgt_data <= next_tgt_data;
			result <= next_result;
			RDATA <= next_rdata;
			LINK.wr <= next_lwr;
			LINK.rd <= next_lrd;
			LINK.addr <= next_laddr;
			LINK.wdata <= next_lwdata;
		end
	end
endmodule // flash_host_end

// ===== otp_query_checker.sv
// assertions on the link between host end and device end
`timescale 1ns/1ps
module otp_query_checker (
	input wire logic        CLK,
	input wire logic        RST,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [15:0] addr,
	input wire logic [15:0] wdata,
	input wire logic [15:0] rdata,
	input wire logic        rvalid,
	input wire logic [7:0]  STATUS
);
	logic pend;
	logic qmode;
	logic next_pend;
	logic next_qmode;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	// ----------------------------------------------------------------
	// read mode tracking
	// ----------------------------------------------------------------
	always_comb begin
		next_pend  = pend;
		next_qmode = qmode;
		if (wr && pend) begin
			next_pend = 1'b0;
		end else if (wr && STATUS[7]) begin
			next_pend  = (wdata[7:0] == 8'hC0);
			next_qmode = (wdata[7:0] == 8'h98) ||
				(qmode && !(wdata[7:0] inside {8'hFF, 8'h70, 8'h90, 8'hC0}));
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			pend  <= 1'b0;
			qmode <= 1'b0;
		end else begin
			pend  <= next_pend;
			qmode <= next_qmode;
		end
	end

	// ----------------------------------------------------------------
	// sequences
	// ----------------------------------------------------------------
	sequence s_prog;
		wr && !pend && STATUS[7] && wdata[7:0] == 8'hC0 ##1 wr;
	endsequence
	sequence s_prog_out;
		wr && !pend && STATUS[7] && wdata[7:0] == 8'hC0 &&
			(addr < 16'h0080 || addr > 16'h0109) ##1 wr;
	endsequence
	sequence s_qrd;
		rd && qmode && !pend && STATUS[7];
	endsequence

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	chk_rd_answer: assert property (rd |=> rvalid)
		else $error("read not answered in the next cycle");
	chk_rvalid_cause: assert property (rvalid |-> $past(rd))
		else $error("answer without a read");
	chk_rdata_idle: assert property (!rvalid |-> rdata == 16'h0000)
		else $error("read data not zero outside answer");
	chk_query_high: assert property (s_qrd |=> rdata[15:8] == 8'h00)
		else $error("query high byte not zero");
	chk_query_string: assert property (s_qrd ##0 (addr >= 16'h0010 && addr <= 16'h0012) |=>
		rdata == {8'h00, $past(addr) == 16'h0010 ? 8'h51 :
			($past(addr) == 16'h0011 ? 8'h52 : 8'h59)})
		else $error("query string wrong");
	chk_query_pointer: assert property (s_qrd ##0 (addr == 16'h0015 || addr == 16'h0016) |=>
		rdata == (($past(addr) == 16'h0015) ? 16'h000A : 16'h0001))
		else $error("table pointer wrong");
	chk_query_empty: assert property (s_qrd ##0 (addr >= 16'h0017 || addr < 16'h0010) |=>
		rdata == 16'h0000)
		else $error("empty query offset not zero");
	chk_prog_busy: assert property (s_prog |-> ##[1:2] !STATUS[7] ##1 (!STATUS[7]) [*3]
		##[1:4] STATUS[7])
		else $error("program busy window wrong");
	chk_prog_range: assert property (s_prog_out |-> ##[1:8] (STATUS[7] && STATUS[4]))
		else $error("out of range program without error");
	chk_lock_pair: assert property (STATUS[1] |-> STATUS[4])
		else $error("lock error without program error");
endmodule // otp_query_checker

// ===== otp_lock_and_query_table_tb.sv
// self-checking bench for the security register and query link
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module otp_lock_and_query_table_tb;
	// store default factory content and an arbitrary command set code
	localparam logic [63:0] FACTORY = 64'h0123_4567_89AB_CDEF;
	localparam logic [15:0] CMDSET  = 16'h3C5A;
	logic        CLK    = 1'b0;
	logic        RST    = 1'b1;
	logic [3:0]  ADDR   = 4'h0;
	logic [15:0] WDATA  = 16'h0000;
	logic        WR     = 1'b0;
	logic        RD     = 1'b0;
	logic [15:0] RDATA;
	logic [7:0]  STATUS;
	int          errors = 0;
	int          num_checks = 0;
	logic [15:0] sec [0:137];
	logic        pe = 1'b0;
	logic        le = 1'b0;
	logic [15:0] res;
	int          a;
	int          k;

	flash_link_if link_i ();
	flash_host_end flash_host_end_i (.CLK(CLK), .RST(RST), .LINK(link_i.host), .ADDR(ADDR),
		.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA));
	flash_device_end #(.PRIMARY_CMDSET(CMDSET)) flash_device_end_i (.CLK(CLK), .RST(RST),
		.LINK(link_i.device), .STATUS(STATUS));
	otp_query_checker otp_query_checker_i (.CLK(CLK), .RST(RST), .wr(link_i.wr),
		.rd(link_i.rd), .addr(link_i.addr), .wdata(link_i.wdata), .rdata(link_i.rdata),
		.rvalid(link_i.rvalid), .STATUS(STATUS));

	always #20 CLK = ~CLK;

	// ----------------------------------------------------------------
	// model
	// ----------------------------------------------------------------
	function automatic logic locked(int a);
		if (a >= 16'h0081 && a <= 16'h0084) return !sec[0][0];
		if (a >= 16'h0085 && a <= 16'h0088) return !sec[0][1];
		if (a >= 16'h008A && a <= 16'h0109) return !sec[9][(a - 16'h008A) / 8];
		return 1'b0;
	endfunction
	function automatic logic [15:0] wexp(int a);
		return (a >= 16'h0080 && a <= 16'h0109) ? sec[a - 16'h0080] : 16'h0000;
	endfunction
	function automatic logic [15:0] qexp(int a);
		case (a)
			16'h0010: return 16'h0051;
			16'h0011: return 16'h0052;
			16'h0012: return 16'h0059;
			16'h0013: return {8'h00, CMDSET[7:0]};
			16'h0014: return {8'h00, CMDSET[15:8]};
			16'h0015: return 16'h000A;
			16'h0016: return 16'h0001;
			default: return 16'h0000;
		endcase
	endfunction
	function automatic logic [7:0] sexp();
		return {1'b1, 2'b00, pe, 2'b00, le, 1'b0};
	endfunction

	// ----------------------------------------------------------------
	// register port tasks
	// ----------------------------------------------------------------
	task automatic reg_wr(input logic [3:0] ra, input logic [15:0] d);
		@(posedge CLK);
		ADDR  <= ra;
		WDATA <= d;
		WR    <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
	endtask
	task automatic reg_rd(input logic [3:0] ra, output logic [15:0] d);
		@(posedge CLK);
		ADDR <= ra;
		RD   <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		@(negedge CLK);
		d = RDATA;
	endtask
	task complete_run;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic do_op(input logic [2:0] op, input int ta, input logic [15:0] d);
		int i;
		logic [15:0] v;
		reg_wr(4'h1, ta[15:0]);
		reg_wr(4'h2, d);
		reg_wr(4'h0, {13'h0000, op});
		for (i = 0; i < 40; i++) begin
			reg_rd(4'h0, v);
			if (v[0] === 1'b0) break;
		end
		if (i < 40)
			for (i = 0; i < 40 && STATUS[7] !== 1'b1; i++) @(negedge CLK);
		if (i >= 40) begin
			`CHK(1'b0, 1'b1)
			complete_run;
		end
		reg_rd(4'h3, res);
	endtask
	task automatic prog(input int ta, input logic [15:0] d);
		if (ta < 16'h0080 || ta > 16'h0109) pe = 1'b1;
		else if (locked(ta)) begin
			pe = 1'b1;
			le = 1'b1;
		end else sec[ta - 16'h0080] &= d;
		do_op(3'h1, ta, d);
		`CHK(STATUS, sexp())
		do_op(3'h2, ta, 16'h0000);
		`CHK(res, wexp(ta))
	endtask
	task automatic clear;
		do_op(3'h5, 0, 16'h0000);
		pe = 1'b0;
		le = 1'b0;
		`CHK(STATUS, 8'h80)
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(62547));
		for (a = 0; a < 138; a++) sec[a] = 16'hFFFF;
		sec[0] = 16'hFFFE;
		for (a = 1; a < 5; a++) sec[a] = FACTORY[16 * (a - 1) +: 16];
		repeat (20) @(posedge CLK);
		RST <= 1'b0;
		@(negedge CLK);
		`CHK(STATUS, 8'h80)
		for (a = 16'h0080; a < 16'h0085; a++) begin
			do_op(3'h2, a, 16'h0000);
			`CHK(res, wexp(a))
		end
		do_op(3'h2, 16'h0010, 16'h0000);
		`CHK(res, 16'h0000)
		for (a = 0; a < 16'h0030; a++) begin
			do_op(3'h3, a, 16'h0000);
			`CHK(res, qexp(a))
		end
		prog(16'h0085, 16'($urandom));
		prog(16'h0085, 16'($urandom));
		prog(16'h0082, 16'h0000);
		do_op(3'h4, 0, 16'h0000);
		`CHK(res, {8'h00, sexp()})
		clear();
		prog(16'h007F, 16'h0000);
		prog(16'h010A, 16'h1234);
		clear();
		prog(16'h0080, 16'hFFFD);
		prog(16'h0086, 16'h00FF);
		clear();
		prog(16'h0080, 16'hFFFF);
		k = $urandom_range(15, 0);
		prog(16'h0089, ~(16'h0001 << k));
		prog(16'h008A + 8 * k + $urandom_range(7, 0), 16'($urandom));
		clear();
		prog(16'h008A + 8 * ((k + 1) % 16), 16'h1234);
		complete_run;
	end
endmodule // otp_lock_and_query_table_tb
